// ===== inc/timer_cmp_consts.vh
// Constants of the timer compare, one-pulse and PWM block.
// Assumes a 20 MHz reference clock and an Avalon-MM slave with byte addresses.
`ifndef TIMER_CMP_CONSTS_VH
`define TIMER_CMP_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TC_ADDR_CTRL_ONE 6'h00
`define TC_ADDR_CTRL_TWO 6'h04
`define TC_ADDR_STATUS 6'h08
`define TC_ADDR_CAP1_HI 6'h0C
`define TC_ADDR_CAP1_LO 6'h10
`define TC_ADDR_CMP1_HI 6'h14
`define TC_ADDR_CMP1_LO 6'h18
`define TC_ADDR_CMP2_HI 6'h1C
`define TC_ADDR_CMP2_LO 6'h20
`define TC_ADDR_CAP2_HI 6'h24
`define TC_ADDR_CAP2_LO 6'h28
`define TC_ADDR_CNT_HI 6'h2C
`define TC_ADDR_CNT_LO 6'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TC_C1_CAP_IRQ_EN 7
`define TC_C1_CMP_IRQ_EN 6
`define TC_C1_OVF_IRQ_EN 5
`define TC_C1_FORCE_TWO 4
`define TC_C1_PULSE_LEVEL 2
`define TC_C1_CAP_ONE_EDGE 1
`define TC_C1_AFTER_LEVEL 0
`define TC_C2_PIN_ONE_EN 7
`define TC_C2_PIN_TWO_EN 6
`define TC_C2_SINGLE_SHOT 5
`define TC_C2_PWM 4
`define TC_C2_CLK_SEL_HI 3
`define TC_C2_CLK_SEL_LO 2
`define TC_C2_CAP_TWO_EDGE 1
`define TC_C2_EXT_EDGE 0
`define TC_C1_FORCE_ONE 3
`define TC_SR_CAP_ONE 7
`define TC_SR_CMP_ONE 6
`define TC_SR_OVF 5
`define TC_SR_CAP_TWO 4
`define TC_SR_CMP_TWO 3

// ----------------------------------------------------------------
// Clock select codes, reset values, reload values
// ----------------------------------------------------------------
`define TC_CC_DIV4 2'h0
`define TC_CC_DIV2 2'h1
`define TC_CC_DIV8 2'h2
`define TC_CC_EXT 2'h3
`define TC_CTRL_RST 8'h00
`define TC_CMP_RST 16'h8000
`define TC_CMP_HI_RST 8'h80
`define TC_CAP_RST 16'h0000
`define TC_CNT_RELOAD 16'hFFFC
`define TC_CAP_TRIG_VAL 16'hFFFD
`define TC_CNT_MAX 16'hFFFF
`define TC_CNT_ONE 16'h0001
`define TC_PRESC_ONE 3'h1

`endif

// ===== rtl/timer_compare_pulse_pwm.v
// 16-bit free-running timer: output compare, forced levels, one-pulse and PWM.
// Assumes an Avalon-MM master on REF_CLK_I; pins arrive unsynchronised.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`include "timer_cmp_consts.vh"
`default_nettype none

module timer_compare_pulse_pwm (
  input wire REF_CLK_I,
  input wire RESETN_I,
  input wire [5:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  input wire EXT_CLK_I,
  input wire CAPTURE_PIN_ONE_I,
  input wire CAPTURE_PIN_TWO_I,
  output reg COMPARE_OUTPUT_PIN_ONE_O,
  output reg COMPARE_OUTPUT_PIN_ONE_SEL_O,
  output reg COMPARE_OUTPUT_PIN_TWO_O,
  output reg COMPARE_OUTPUT_PIN_TWO_SEL_O,
  output reg TIMER_IRQ_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] ctrl_one;
  reg [7:0] ctrl_two;
  reg [15:0] cnt;
  reg [2:0] presc;
  reg [15:0] compare_value_one;
  reg [15:0] compare_value_two;
  reg [15:0] cmp_active_one;
  reg [15:0] cmp_active_two;
  reg [7:0] cmp_hi_one;
  reg [7:0] cmp_hi_two;
  reg cmp_inh_one, cmp_inh_two;
  reg [15:0] capture_value_one;
  reg [15:0] capture_value_two;
  reg cap_inh_one, cap_inh_two;
  reg capture_flag_one, capture_flag_two;
  reg compare_match_flag_one, compare_match_flag_two;
  reg ovf_flag;
  reg arm_cap_one, arm_cap_two, arm_cmp_one, arm_cmp_two, arm_ovf;
  reg ext_s1, ext_s2, ext_s3;
  reg cp1_s1, cp1_s2, cp1_s3;
  reg cp2_s1, cp2_s2, cp2_s3;
  reg [7:0] rd_mux;

  // ----------------------------------------------------------------
  // Decoded modes and events
  // ----------------------------------------------------------------
  wire mode_pwm = ctrl_two[`TC_C2_PWM];
  wire mode_opm = ctrl_two[`TC_C2_SINGLE_SHOT] & ~mode_pwm;
  wire mode_norm = ~ctrl_two[`TC_C2_SINGLE_SHOT] & ~mode_pwm;
  wire [1:0] timer_clock_select = ctrl_two[`TC_C2_CLK_SEL_HI:`TC_C2_CLK_SEL_LO];
  wire pulse_level = ctrl_one[`TC_C1_PULSE_LEVEL];
  wire after_pulse_level = ctrl_one[`TC_C1_AFTER_LEVEL];
  // Edges use stages two and three only, never the first flop
  wire ext_rise = ext_s2 & ~ext_s3;
  wire ext_fall = ~ext_s2 & ext_s3;
  wire ext_edge = ctrl_two[`TC_C2_EXT_EDGE] ? ext_rise : ext_fall;
  wire cap1_edge = ctrl_one[`TC_C1_CAP_ONE_EDGE] ? (cp1_s2 & ~cp1_s3) : (~cp1_s2 & cp1_s3);
  wire cap2_edge = ctrl_two[`TC_C2_CAP_TWO_EDGE] ? (cp2_s2 & ~cp2_s3) : (~cp2_s2 & cp2_s3);
  // Prescaler taps of a free-running 3-bit count
  reg tick;
  always @* begin
    case (timer_clock_select)
      `TC_CC_DIV2: tick = presc[0];
      `TC_CC_DIV4: tick = &presc[1:0];
      `TC_CC_DIV8: tick = &presc;
      default: tick = ext_edge;
    endcase
  end
  // Matches hold for the whole time the counter sits on the value
  wire eq_one = (cnt == cmp_active_one);
  wire eq_two = (cnt == cmp_active_two);
  wire trig_one = mode_opm & cap1_edge;
  wire period_end = mode_pwm & eq_two & tick;
  // Bus request decode
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire acc = req & ~AVS_WAITREQUEST_O;
  wire wr_acc = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  wire rd_acc = acc & AVS_READ_I;
  wire [7:0] wdata = AVS_WRITEDATA_I[7:0];
  wire wr_cmp1_hi = wr_acc & (AVS_ADDRESS_I == `TC_ADDR_CMP1_HI);
  wire wr_cmp1_lo = wr_acc & (AVS_ADDRESS_I == `TC_ADDR_CMP1_LO);
  wire wr_cmp2_hi = wr_acc & (AVS_ADDRESS_I == `TC_ADDR_CMP2_HI);
  wire wr_cmp2_lo = wr_acc & (AVS_ADDRESS_I == `TC_ADDR_CMP2_LO);
  wire acc_cmp1_lo = acc & (AVS_ADDRESS_I == `TC_ADDR_CMP1_LO);
  wire acc_cmp2_lo = acc & (AVS_ADDRESS_I == `TC_ADDR_CMP2_LO);
  wire acc_cap1_lo = acc & (AVS_ADDRESS_I == `TC_ADDR_CAP1_LO);
  wire acc_cap2_lo = acc & (AVS_ADDRESS_I == `TC_ADDR_CAP2_LO);
  wire acc_cnt_lo = acc & (AVS_ADDRESS_I == `TC_ADDR_CNT_LO);
  wire rd_cap1_hi = rd_acc & (AVS_ADDRESS_I == `TC_ADDR_CAP1_HI);
  wire rd_cap2_hi = rd_acc & (AVS_ADDRESS_I == `TC_ADDR_CAP2_HI);
  wire rd_status = rd_acc & (AVS_ADDRESS_I == `TC_ADDR_STATUS);
  // Flag set terms; hardware never sets compare flags in PWM
  wire set_cmp_one = mode_norm & eq_one & ~cmp_inh_one;
  wire set_cmp_two = ~mode_pwm & eq_two & ~cmp_inh_two;
  wire set_cap_one = (mode_norm & cap1_edge & ~cap_inh_one) | trig_one | period_end;
  wire set_cap_two = cap2_edge & ~cap_inh_two;
  wire cnt_wrap = tick & (cnt == `TC_CNT_MAX) & ~trig_one & ~period_end;
  // Clear terms: armed by a status read, fired by the low-byte access
  wire clr_cap_one = arm_cap_one & acc_cap1_lo;
  wire clr_cap_two = arm_cap_two & acc_cap2_lo;
  wire clr_cmp_one = arm_cmp_one & acc_cmp1_lo;
  wire clr_cmp_two = arm_cmp_two & acc_cmp2_lo;
  wire clr_ovf = arm_ovf & acc_cnt_lo;

  wire [7:0] status_byte = {capture_flag_one, compare_match_flag_one, ovf_flag,
                            capture_flag_two, compare_match_flag_two, 3'h0};

  // ----------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      cp1_s1 <= 1'b0;
      cp1_s2 <= 1'b0;
      cp1_s3 <= 1'b0;
      cp2_s1 <= 1'b0;
      cp2_s2 <= 1'b0;
      cp2_s3 <= 1'b0;
      presc <= 3'h0;
    end else begin
      ext_s1 <= EXT_CLK_I;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      cp1_s1 <= CAPTURE_PIN_ONE_I;
      cp1_s2 <= cp1_s1;
      cp1_s3 <= cp1_s2;
      cp2_s1 <= CAPTURE_PIN_TWO_I;
      cp2_s2 <= cp2_s1;
      cp2_s3 <= cp2_s2;
      presc <= presc + `TC_PRESC_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Free-running counter
  // ----------------------------------------------------------------
  // Reload beats the tick so a trigger landing on a tick is never lost
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cnt <= `TC_CNT_RELOAD;
    end else if (trig_one | period_end) begin
      cnt <= `TC_CNT_RELOAD;
    end else if (tick) begin
      cnt <= cnt + `TC_CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  // Read mux; reserved bits and unmapped addresses read zero
  always @* begin
    case (AVS_ADDRESS_I)
      `TC_ADDR_CTRL_ONE: rd_mux = ctrl_one;
      `TC_ADDR_CTRL_TWO: rd_mux = ctrl_two;
      `TC_ADDR_STATUS: rd_mux = status_byte;
      `TC_ADDR_CAP1_HI: rd_mux = capture_value_one[15:8];
      `TC_ADDR_CAP1_LO: rd_mux = capture_value_one[7:0];
      `TC_ADDR_CMP1_HI: rd_mux = compare_value_one[15:8];
      `TC_ADDR_CMP1_LO: rd_mux = compare_value_one[7:0];
      `TC_ADDR_CMP2_HI: rd_mux = compare_value_two[15:8];
      `TC_ADDR_CMP2_LO: rd_mux = compare_value_two[7:0];
      `TC_ADDR_CAP2_HI: rd_mux = capture_value_two[15:8];
      `TC_ADDR_CAP2_LO: rd_mux = capture_value_two[7:0];
      `TC_ADDR_CNT_HI: rd_mux = cnt[15:8];
      `TC_ADDR_CNT_LO: rd_mux = cnt[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  // One wait state: data is snapshotted, then the request is taken
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (req & AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O <= AVS_READ_I ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // Control registers
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      ctrl_one <= `TC_CTRL_RST;
      ctrl_two <= `TC_CTRL_RST;
    end else if (wr_acc) begin
      if (AVS_ADDRESS_I == `TC_ADDR_CTRL_ONE) begin
        ctrl_one <= wdata;
      end
      if (AVS_ADDRESS_I == `TC_ADDR_CTRL_TWO) begin
        ctrl_two <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare registers and their buffered copies
  // ----------------------------------------------------------------
  // The word commits only with its low byte, so a half-written value never compares
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      compare_value_one <= `TC_CMP_RST;
      compare_value_two <= `TC_CMP_RST;
      cmp_hi_one <= `TC_CMP_HI_RST;
      cmp_hi_two <= `TC_CMP_HI_RST;
      cmp_inh_one <= 1'b0;
      cmp_inh_two <= 1'b0;
    end else begin
      if (wr_cmp1_hi) begin
        cmp_hi_one <= wdata;
        cmp_inh_one <= 1'b1;
      end
      if (wr_cmp1_lo) begin
        compare_value_one <= {cmp_hi_one, wdata};
        cmp_inh_one <= 1'b0;
      end
      if (wr_cmp2_hi) begin
        cmp_hi_two <= wdata;
        cmp_inh_two <= 1'b1;
      end
      if (wr_cmp2_lo) begin
        compare_value_two <= {cmp_hi_two, wdata};
        cmp_inh_two <= 1'b0;
      end
    end
  end

  // Active copies follow at once, except in PWM where they wait for the period end
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cmp_active_one <= `TC_CMP_RST;
      cmp_active_two <= `TC_CMP_RST;
    end else if (~mode_pwm | period_end) begin
      cmp_active_one <= compare_value_one;
      cmp_active_two <= compare_value_two;
    end
  end

  // ----------------------------------------------------------------
  // Capture registers
  // ----------------------------------------------------------------
  // Reading the high byte freezes the pair until the low byte is read, except that a one-pulse trigger still loads capture one
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      capture_value_one <= `TC_CAP_RST;
      capture_value_two <= `TC_CAP_RST;
      cap_inh_one <= 1'b0;
      cap_inh_two <= 1'b0;
    end else begin
      if (trig_one) begin
        capture_value_one <= `TC_CAP_TRIG_VAL;
      end else if (mode_norm & cap1_edge & ~cap_inh_one) begin
        capture_value_one <= cnt;
      end
      if (set_cap_two) begin
        capture_value_two <= cnt;
      end
      if (rd_cap1_hi) begin
        cap_inh_one <= 1'b1;
      end else if (acc_cap1_lo & AVS_READ_I) begin
        cap_inh_one <= 1'b0;
      end
      if (rd_cap2_hi) begin
        cap_inh_two <= 1'b1;
      end else if (acc_cap2_lo & AVS_READ_I) begin
        cap_inh_two <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle survives
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      capture_flag_one <= 1'b0;
      capture_flag_two <= 1'b0;
      compare_match_flag_one <= 1'b0;
      compare_match_flag_two <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      capture_flag_one <= set_cap_one | (capture_flag_one & ~clr_cap_one);
      capture_flag_two <= set_cap_two | (capture_flag_two & ~clr_cap_two);
      compare_match_flag_one <= set_cmp_one | (compare_match_flag_one & ~clr_cmp_one);
      compare_match_flag_two <= set_cmp_two | (compare_match_flag_two & ~clr_cmp_two);
      ovf_flag <= cnt_wrap | (ovf_flag & ~clr_ovf);
    end
  end

  // Arm bits take the flags as the status read actually returned them
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      arm_cap_one <= 1'b0;
      arm_cap_two <= 1'b0;
      arm_cmp_one <= 1'b0;
      arm_cmp_two <= 1'b0;
      arm_ovf <= 1'b0;
    end else if (rd_status) begin
      arm_cap_one <= AVS_READDATA_O[`TC_SR_CAP_ONE];
      arm_cap_two <= AVS_READDATA_O[`TC_SR_CAP_TWO];
      arm_cmp_one <= AVS_READDATA_O[`TC_SR_CMP_ONE];
      arm_cmp_two <= AVS_READDATA_O[`TC_SR_CMP_TWO];
      arm_ovf <= AVS_READDATA_O[`TC_SR_OVF];
    end else begin
      if (acc_cap1_lo) begin
        arm_cap_one <= 1'b0;
      end
      if (acc_cap2_lo) begin
        arm_cap_two <= 1'b0;
      end
      if (acc_cmp1_lo) begin
        arm_cmp_one <= 1'b0;
      end
      if (acc_cmp2_lo) begin
        arm_cmp_two <= 1'b0;
      end
      if (acc_cnt_lo) begin
        arm_ovf <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare output pins
  // ----------------------------------------------------------------
  // The pin latch only moves while its pin enable routes it out
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      COMPARE_OUTPUT_PIN_ONE_O <= 1'b0;
      COMPARE_OUTPUT_PIN_TWO_O <= 1'b0;
    end else begin
      if (ctrl_two[`TC_C2_PIN_ONE_EN]) begin
        if (mode_pwm) begin
          if (eq_two) begin
            COMPARE_OUTPUT_PIN_ONE_O <= pulse_level;
          end else if (eq_one) begin
            COMPARE_OUTPUT_PIN_ONE_O <= after_pulse_level;
          end
        end else if (mode_opm) begin
          if (trig_one) begin
            COMPARE_OUTPUT_PIN_ONE_O <= pulse_level;
          end else if (eq_one) begin
            COMPARE_OUTPUT_PIN_ONE_O <= after_pulse_level;
          end
        end else if (ctrl_one[`TC_C1_FORCE_ONE]) begin
          COMPARE_OUTPUT_PIN_ONE_O <= after_pulse_level;
        end else if (eq_one & ~cmp_inh_one) begin
          COMPARE_OUTPUT_PIN_ONE_O <= after_pulse_level;
        end
      end
      // Channel two drives no waveform outside ordinary compare
      if (ctrl_two[`TC_C2_PIN_TWO_EN] & mode_norm) begin
        if (ctrl_one[`TC_C1_FORCE_TWO]) begin
          COMPARE_OUTPUT_PIN_TWO_O <= pulse_level;
        end else if (eq_two & ~cmp_inh_two) begin
          COMPARE_OUTPUT_PIN_TWO_O <= pulse_level;
        end
      end
    end
  end

  // Pin routing and interrupt request, registered
  always @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      COMPARE_OUTPUT_PIN_ONE_SEL_O <= 1'b0;
      COMPARE_OUTPUT_PIN_TWO_SEL_O <= 1'b0;
      TIMER_IRQ_O <= 1'b0;
    end else begin
      COMPARE_OUTPUT_PIN_ONE_SEL_O <= ctrl_two[`TC_C2_PIN_ONE_EN];
      COMPARE_OUTPUT_PIN_TWO_SEL_O <= ctrl_two[`TC_C2_PIN_TWO_EN] & mode_norm;
      TIMER_IRQ_O <= (ctrl_one[`TC_C1_CAP_IRQ_EN] & (capture_flag_one | capture_flag_two))
                   | (ctrl_one[`TC_C1_CMP_IRQ_EN] & (compare_match_flag_one | compare_match_flag_two))
                   | (ctrl_one[`TC_C1_OVF_IRQ_EN] & ovf_flag);
    end
  end

endmodule // timer_compare_pulse_pwm
`default_nettype wire

// ===== testbench/timer_cmp_checker_asserts.sv
// Checker for the timer block: bus handshake, pin routing, forced and mode levels.
// Assumes it is bound to the top module; control bytes are shadowed from bus writes.
`include "timer_cmp_consts.vh"
`default_nettype none
module timer_cmp_checker (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic COMPARE_OUTPUT_PIN_ONE_O,
  input wire logic COMPARE_OUTPUT_PIN_ONE_SEL_O,
  input wire logic COMPARE_OUTPUT_PIN_TWO_O,
  input wire logic TIMER_IRQ_O
);
  logic [7:0] c1;
  logic [7:0] c2;
  logic taken;
  logic plain;
  // ----
  // Control shadows
  // ----
  // A write lands only at the edge that sees waitrequest low
  assign taken = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign plain = !c2[5] && !c2[4];
  // Shadows follow accepted writes to the two control bytes
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
    end else if (taken && AVS_ADDRESS_I == `TC_ADDR_CTRL_ONE) begin
      c1 <= AVS_WRITEDATA_I[7:0];
    end else if (taken && AVS_ADDRESS_I == `TC_ADDR_CTRL_TWO) begin
      c2 <= AVS_WRITEDATA_I[7:0];
    end
  end
  // ----
  // Assertions
  // ----
  // Three settled cycles are asked for, since pins lag control writes by one register
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  chk_wait_answer: assert property (($rose(AVS_READ_I) || $rose(AVS_WRITE_I)) |=> !AVS_WAITREQUEST_O)
    else $error("bus answer late");
  chk_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest held low");
  chk_sel_routes: assert property (COMPARE_OUTPUT_PIN_ONE_SEL_O == $past(c2[7]))
    else $error("pin one routing wrong");
  chk_force_level: assert property ((plain && c2[7] && c1[3] && $stable(c1)) [*3]
    |-> COMPARE_OUTPUT_PIN_ONE_O == c1[0]) else $error("forced level missing");
  chk_gpio_hold: assert property ((plain && !c2[7]) [*3] |-> $stable(COMPARE_OUTPUT_PIN_ONE_O))
    else $error("disabled pin moved");
  chk_pin_two_held: assert property ((c2[5] && !c2[4]) [*3] |-> $stable(COMPARE_OUTPUT_PIN_TWO_O))
    else $error("pin two moved in one-pulse");
  chk_irq_quiet: assert property ((c1[7:5] == 3'h0) [*3] |-> !TIMER_IRQ_O)
    else $error("irq without enable");
  chk_const_level: assert property ((c2[4] && c1[0] == c1[2] && $stable(c1)) [*3]
    |-> $stable(COMPARE_OUTPUT_PIN_ONE_O) || COMPARE_OUTPUT_PIN_ONE_O == c1[0])
    else $error("pwm pin not constant");
endmodule // timer_cmp_checker
bind timer_compare_pulse_pwm timer_cmp_checker i_chk (.REF_CLK_I, .RESETN_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .COMPARE_OUTPUT_PIN_ONE_O,
  .COMPARE_OUTPUT_PIN_ONE_SEL_O, .COMPARE_OUTPUT_PIN_TWO_O, .TIMER_IRQ_O);
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the timer compare, one-pulse and PWM block.
// Assumes the design, its constants header and the bound checker are compiled with it.
`include "timer_cmp_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic cap_one = 1'b0;
  logic cap_two = 1'b0;
  logic ext_clk = 1'b0;
  logic [31:0] rdata;
  logic waitreq, pin_one, pin_one_sel, pin_two, pin_two_sel, irq;
  logic [7:0] rb;
  int n_fail = 0;
  int check_count = 0;
  int n;
  int t0;
  int cyc = 0;
  // Byte enables stay full; only the low lane carries data
  timer_compare_pulse_pwm i_timer_compare_pulse_pwm (.REF_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .EXT_CLK_I(ext_clk), .CAPTURE_PIN_ONE_I(cap_one),
    .CAPTURE_PIN_TWO_I(cap_two), .COMPARE_OUTPUT_PIN_ONE_O(pin_one), .COMPARE_OUTPUT_PIN_ONE_SEL_O(pin_one_sel),
    .COMPARE_OUTPUT_PIN_TWO_O(pin_two), .COMPARE_OUTPUT_PIN_TWO_SEL_O(pin_two_sel), .TIMER_IRQ_O(irq));
  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Edge count, so a span can be timed across bus accesses
  always @(posedge clk) cyc <= cyc + 1;
  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; held until waitrequest is sampled low, read data taken at that edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    rb = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    check("bus answer", 8'h01, 8'(k < 20));
  endtask
  // High byte first, so matching stays inhibited until the word is whole
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    acc(1'b1, a, v[15:8]);
    acc(1'b1, a + 6'h04, v[7:0]);
  endtask
  // Cycles until pin one shows v, bounded
  task automatic wait_pin(input logic v, output int c);
    c = 0;
    while (pin_one !== v && c < 3000) begin
      @(posedge clk);
      c++;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    acc(1'b0, `TC_ADDR_CMP2_HI, 8'h00);
    check("compare two high", 8'h80, rb);
    acc(1'b0, `TC_ADDR_CMP2_LO, 8'h00);
    check("compare two low", 8'h00, rb);
    $display("t_reset done");
  endtask
  task automatic t_match();
    acc(1'b1, `TC_ADDR_CTRL_TWO, 8'h44);
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h45);
    wr16(`TC_ADDR_CMP1_HI, 16'h0040);
    wr16(`TC_ADDR_CMP2_HI, 16'h0040);
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    check("match irq", 8'h01, {7'h00, irq});
    check("pin one untouched", 8'h00, {6'h00, pin_one_sel, pin_one});
    check("pin two driven", 8'h03, {6'h00, pin_two_sel, pin_two});
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("compare flags", 8'h48, rb & 8'h48);
    wr16(`TC_ADDR_CMP1_HI, 16'h4000);
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("flag one cleared", 8'h08, rb & 8'h48);
    $display("t_match done");
  endtask
  task automatic t_force();
    acc(1'b1, `TC_ADDR_CTRL_TWO, 8'hC4);
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h09);
    repeat (3) @(posedge clk);
    check("forced pin", 8'h03, {6'h00, pin_one_sel, pin_one});
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("no forced flag", 8'h00, rb & 8'h40);
    acc(1'b1, `TC_ADDR_CTRL_TWO, 8'hE4);
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h08);
    repeat (3) @(posedge clk);
    check("force ignored", 8'h01, {7'h00, pin_one});
    check("pin two released", 8'h00, {7'h00, pin_two_sel});
    $display("t_force done");
  endtask
  task automatic t_pulse();
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h83);
    wr16(`TC_ADDR_CMP1_HI, 16'h0020);
    cap_one <= 1'b1;
    wait_pin(1'b0, n);
    check("pulse start", 8'h01, 8'(n < 8));
    wait_pin(1'b1, n);
    check("pulse width", 8'h01, 8'(n >= 70 && n <= 74));
    check("trigger irq", 8'h01, {7'h00, irq});
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("pulse flags", 8'h80, rb & 8'hC0);
    acc(1'b0, `TC_ADDR_CAP1_HI, 8'h00);
    check("capture high", 8'hFF, rb);
    acc(1'b0, `TC_ADDR_CAP1_LO, 8'h00);
    check("capture low", 8'hFD, rb);
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("capture flag cleared", 8'h00, rb & 8'h80);
    check("irq released", 8'h00, {7'h00, irq});
    cap_one <= 1'b0;
    $display("t_pulse done");
  endtask
  task automatic t_pwm();
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h04);
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    wr16(`TC_ADDR_CMP2_HI, 16'h0080);
    wr16(`TC_ADDR_CMP1_HI, 16'h0070);
    acc(1'b1, `TC_ADDR_CTRL_TWO, 8'hF4);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    check("low span 32", 8'h20, 8'(n));
    t0 = cyc;
    wr16(`TC_ADDR_CMP1_HI, 16'h0078);
    wait_pin(1'b0, n);
    check("high span 234", 8'hEA, 8'(cyc - t0));
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    check("high span 250", 8'hFA, 8'(n));
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("pwm flags", 8'h80, rb & 8'hC8);
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h05);
    repeat (300) @(posedge clk);
    wait_pin(1'b0, n);
    check("constant level", 8'h01, 8'(n >= 3000));
    $display("t_pwm done");
  endtask
  // External clock ticks and a pin-two capture in one-pulse mode, the counter moving only on external edges
  task automatic t_ext();
    logic [7:0] c0;
    logic [7:0] hi;
    acc(1'b1, `TC_ADDR_CTRL_ONE, 8'h00);
    acc(1'b1, `TC_ADDR_CTRL_TWO, 8'h2F);
    acc(1'b0, `TC_ADDR_CNT_LO, 8'h00);
    c0 = rb;
    repeat (8) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    acc(1'b0, `TC_ADDR_CNT_LO, 8'h00);
    check("external ticks", 8'h08, rb - c0);
    acc(1'b0, `TC_ADDR_CNT_HI, 8'h00);
    hi = rb;
    cap_two <= 1'b1;
    repeat (5) @(posedge clk);
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("capture two flag", 8'h10, rb & 8'h10);
    acc(1'b0, `TC_ADDR_CAP2_HI, 8'h00);
    check("capture two high", hi, rb);
    acc(1'b0, `TC_ADDR_CAP2_LO, 8'h00);
    check("capture two low", c0 + 8'h08, rb);
    acc(1'b0, `TC_ADDR_STATUS, 8'h00);
    check("capture two cleared", 8'h00, rb & 8'h10);
    $display("t_ext done");
  endtask
  // ----
  // Run control
  // ----
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Tests take under 6000 cycles
  initial begin
    #(50 * 20000);
    n_fail++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end
  // Reset for three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_match();
    t_force();
    t_pulse();
    t_pwm();
    t_ext();
    end_sim();
  end
endmodule // tb
`default_nettype wire
